//--- logic/dcp_consts.vh
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH

// bits per byte on either protocol
`define DCP_BYTE_BITS 4'd8
// last bit index inside a byte
`define DCP_LAST_BIT 4'd7
// transfer-type field of the three-wire address byte, written {bit1, bit0}
`define DCP_TW_TYPE_WRITE 2'b10
`define DCP_TW_TYPE_READ 2'b11
// field positions of the three-wire address byte
`define DCP_TW_TYPE_LSB 0
`define DCP_TW_ADDR_LSB 2
// flag in bit 0 of the three-wire register byte
`define DCP_FLAG_WRITE 1'b0
`define DCP_FLAG_PREPARE 1'b1
// register pointer after reset
`define DCP_REG_ADDR_RESET 8'h00
// highest bus clock the host may use, in kHz
`define DCP_I2C_FMAX_KHZ 400

`endif

//--- logic/dcp_sync.v
`timescale 1ns/1ps

// two-flop synchroniser per bit plus a third stage for edge finding
module dcp_sync #(
   parameter WIDTH = 4
) (
   input wire clk,
   input wire srst,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise,
   output wire [WIDTH-1:0] fall
);
   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;
   reg [WIDTH-1:0] last;
   reg [2:0] warm;

   // edges compare the second and third stage only, never the first
   always @(posedge clk) begin
      if (srst) begin
         meta <= {WIDTH{1'b0}};
         stable <= {WIDTH{1'b0}};
         last <= {WIDTH{1'b0}};
         warm <= 3'b000;
      end else begin
         meta <= async_in;
         stable <= meta;
         last <= stable;
         warm <= {warm[1:0], 1'b1};
      end
   end

   // no edges until every stage holds a real pin level, else an idle-high pin looks like a rise
   assign level = stable;
   assign rise = warm[2] ? (stable & ~last) : {WIDTH{1'b0}};
   assign fall = warm[2] ? (~stable & last) : {WIDTH{1'b0}};
endmodule // dcp_sync

//--- logic/dcp_control_port.v
// Operation
// [RULE_01] strap low picks three-wire bus, high picks I2C slave on shared pins
// [RULE_02] in I2C mode the phase pin becomes DAC mute, high mutes
// [RULE_03] three-wire bytes travel least significant bit first
// [RULE_04] host addresses with phase low and exactly eight clock pulses
// [RULE_05] phase high carries data bytes to the last addressed device
// [RULE_06] address byte bits 0-1 are transfer type, bits 2-7 device address
// [RULE_07] type 0 then 1 is write or prepare read, 1 and 1 is read
// [RULE_08] first data byte: bit 0 flag, then register address A6 down to A0
// [RULE_09] write is four bytes: address, register, high data, low data
// [RULE_10] host resends device address before each new register access
// [RULE_11] read spans six bytes, device returns register byte and two data bytes
// [RULE_12] returned register byte bit 0 is 0 if register exists, 1 if not
// [RULE_13] I2C master only starts when both lines idle high
// [RULE_14] one bit per clock pulse, data change while clock high is a condition
// [RULE_15] I2C master keeps clock at or below 400 kHz
// [RULE_16] I2C bytes are eight bits, most significant first
// [RULE_17] start is data falling with clock high, stop is data rising
// [RULE_18] ninth clock carries acknowledge from the receiving party
// [RULE_19] acknowledger holds data low through clock high, master releases it
// [RULE_20] master ends read with no acknowledge, slave releases data high
// [RULE_21] bytes between start and stop are not limited
// [RULE_22] I2C write: register address then 16-bit pairs high first, auto increment
// [RULE_23] I2C read: address write, repeated start, pairs high first, auto increment
// [RULE_24] three-wire data sampled on clock rise, read data changed on clock fall
`timescale 1ns/1ps
`include "dcp_consts.vh"

module dcp_control_port #(
   // arbitrary value, not any real part's address
   parameter [5:0] TW_DEV_ADDR = 6'h2a,
   // arbitrary value, not any real part's address
   parameter [6:0] I2C_DEV_ADDR = 7'h5a
) (
   input wire clk,
   input wire srst,
   input wire protocol_select_strap,
   input wire host_clock_pin,
   input wire host_data_pin_in,
   output reg host_data_pin_out,
   output reg host_data_pin_oe_n,
   input wire host_phase_pin,
   output reg dac_mute,
   output reg i2c_mode,
   output reg [7:0] reg_addr,
   output reg reg_wr_stb,
   output reg [15:0] reg_wdata,
   output reg reg_rd_stb,
   input wire [15:0] reg_rdata,
   input wire reg_exists
);
   // three-wire selection
   localparam [1:0] TW_NONE = 2'd0;
   localparam [1:0] TW_WRITE = 2'd1;
   localparam [1:0] TW_READ = 2'd2;
   // three-wire byte slot within one data phase
   localparam [1:0] SLOT_REG = 2'd0;
   localparam [1:0] SLOT_HI = 2'd1;
   localparam [1:0] SLOT_LO = 2'd2;
   localparam [1:0] SLOT_DONE = 2'd3;
   // I2C states
   localparam [2:0] I2C_IDLE = 3'd0;
   localparam [2:0] I2C_DEV = 3'd1;
   localparam [2:0] I2C_REG = 3'd2;
   localparam [2:0] I2C_WDATA = 3'd3;
   localparam [2:0] I2C_RDATA = 3'd4;

   function [7:0] rev8;
      input [7:0] x;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            rev8[i] = x[7 - i];
         end
      end
   endfunction

   wire [3:0] lvl;
   wire [3:0] rse;
   wire [3:0] fll;

   dcp_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .async_in({protocol_select_strap, host_clock_pin, host_data_pin_in, host_phase_pin}),
      .level(lvl),
      .rise(rse),
      .fall(fll)
   );

   wire s_mode = lvl[3];
   wire s_clk = lvl[2];
   wire s_data = lvl[1];
   wire s_phase = lvl[0];
   wire mode_edge = rse[3] | fll[3];
   wire clk_rise = rse[2];
   wire clk_fall = fll[2];
   wire phase_edge = rse[0] | fll[0];
   wire start_cond = fll[1] & s_clk; // see [RULE_17]
   wire stop_cond = rse[1] & s_clk; // see [RULE_17]

   reg [7:0] rx_sr;
   reg [3:0] bit_cnt;
   reg addr_inc;
   reg [1:0] tw_sel;
   reg [1:0] tw_slot;
   reg tw_drive;
   reg tw_bit;
   reg [7:0] tw_cur;
   reg [7:0] hi_hold;
   reg [2:0] i2c_state;
   reg ack_phase;
   reg i2c_pull;
   reg [7:0] tx_sr;
   reg second_byte;
   reg master_nack;

   // byte as it stands after this clock's bit
   wire [7:0] tw_in = {s_data, rx_sr[7:1]}; // see [RULE_03]
   wire [7:0] i2c_in = {rx_sr[6:0], s_data}; // see [RULE_16]
   wire [7:0] tw_val = rev8(tw_in);

   always @(posedge clk) begin
      if (srst || mode_edge) begin
         // a strap change abandons any transfer in flight
         rx_sr <= 8'h00;
         bit_cnt <= 4'd0;
         addr_inc <= 1'b0;
         tw_sel <= TW_NONE;
         tw_slot <= SLOT_DONE;
         tw_drive <= 1'b0;
         tw_bit <= 1'b0;
         tw_cur <= 8'h00;
         hi_hold <= 8'h00;
         i2c_state <= I2C_IDLE;
         ack_phase <= 1'b0;
         i2c_pull <= 1'b0;
         tx_sr <= 8'hff;
         second_byte <= 1'b0;
         master_nack <= 1'b0;
         reg_addr <= `DCP_REG_ADDR_RESET;
         reg_wr_stb <= 1'b0;
         reg_wdata <= 16'h0000;
         reg_rd_stb <= 1'b0;
      end else begin
         reg_wr_stb <= 1'b0;
         reg_rd_stb <= 1'b0;
         addr_inc <= 1'b0;
         if (addr_inc) begin
            reg_addr <= reg_addr + 8'h01; // see [RULE_22]
         end
         if (!s_mode) begin // see [RULE_01]
            if (phase_edge) begin
               // every phase change restarts byte framing
               bit_cnt <= 4'd0;
               tw_slot <= SLOT_REG;
               tw_drive <= 1'b0;
               if (rse[0] && tw_sel == TW_READ) begin
                  tw_cur <= rev8({~reg_exists, reg_addr[6:0]}); // see [RULE_12]
                  tw_bit <= ~reg_exists; // see [RULE_12]
                  tw_drive <= 1'b1; // see [RULE_11]
               end
            end else if (clk_rise && !s_phase) begin
               // address mode; pulses past the eighth are ignored
               if (bit_cnt < `DCP_BYTE_BITS) begin // see [RULE_04]
                  rx_sr <= tw_in;
                  bit_cnt <= bit_cnt + 4'd1;
                  if (bit_cnt == `DCP_LAST_BIT) begin
                     tw_sel <= TW_NONE;
                     if (tw_in[7:`DCP_TW_ADDR_LSB] == TW_DEV_ADDR) begin // see [RULE_06]
                        case (tw_in[`DCP_TW_TYPE_LSB+1:`DCP_TW_TYPE_LSB]) // see [RULE_07]
                           `DCP_TW_TYPE_WRITE: begin
                              tw_sel <= TW_WRITE;
                           end
                           `DCP_TW_TYPE_READ: begin
                              tw_sel <= TW_READ;
                           end
                           default: begin
                              tw_sel <= TW_NONE;
                           end
                        endcase
                     end
                  end
               end
            end else if (clk_rise && tw_sel == TW_WRITE) begin // see [RULE_05]
               rx_sr <= tw_in; // see [RULE_24]
               bit_cnt <= bit_cnt + 4'd1;
               if (bit_cnt == `DCP_LAST_BIT) begin
                  bit_cnt <= 4'd0;
                  case (tw_slot)
                     SLOT_REG: begin
                        reg_addr <= {1'b0, tw_val[6:0]}; // see [RULE_08]
                        if (tw_val[7] == `DCP_FLAG_PREPARE) begin
                           // prepare read: pointer held for the read phase
                           reg_rd_stb <= 1'b1;
                           tw_sel <= TW_NONE; // see [RULE_10]
                           tw_slot <= SLOT_DONE;
                        end else begin
                           tw_slot <= SLOT_HI;
                        end
                     end
                     SLOT_HI: begin
                        hi_hold <= tw_val; // see [RULE_09]
                        tw_slot <= SLOT_LO;
                     end
                     SLOT_LO: begin
                        reg_wdata <= {hi_hold, tw_val}; // see [RULE_09]
                        reg_wr_stb <= 1'b1;
                        tw_sel <= TW_NONE; // see [RULE_10]
                        tw_slot <= SLOT_DONE;
                     end
                     default: begin
                        tw_slot <= SLOT_DONE;
                     end
                  endcase
               end
            end else if (clk_rise && tw_sel == TW_READ && tw_drive) begin
               bit_cnt <= bit_cnt + 4'd1;
               if (bit_cnt == `DCP_LAST_BIT) begin
                  bit_cnt <= 4'd0;
                  case (tw_slot)
                     SLOT_REG: begin
                        tw_cur <= rev8(reg_rdata[15:8]); // see [RULE_11]
                        tw_slot <= SLOT_HI;
                     end
                     SLOT_HI: begin
                        tw_cur <= rev8(reg_rdata[7:0]); // see [RULE_11]
                        tw_slot <= SLOT_LO;
                     end
                     default: begin
                        // last bit sampled: let go of the line
                        tw_drive <= 1'b0;
                        tw_sel <= TW_NONE;
                        tw_slot <= SLOT_DONE;
                     end
                  endcase
               end
            end else if (clk_fall && tw_drive) begin
               tw_bit <= tw_cur[bit_cnt[2:0]]; // see [RULE_24]
            end
         end else begin
            if (start_cond) begin
               // also a repeated start; the pointer survives it
               i2c_state <= I2C_DEV; // see [RULE_13]
               bit_cnt <= 4'd0;
               ack_phase <= 1'b0;
               i2c_pull <= 1'b0;
            end else if (stop_cond) begin
               i2c_state <= I2C_IDLE;
               bit_cnt <= 4'd0;
               ack_phase <= 1'b0;
               i2c_pull <= 1'b0;
            end else if (i2c_state != I2C_IDLE && clk_rise) begin
               if (bit_cnt < `DCP_BYTE_BITS) begin
                  rx_sr <= i2c_in; // see [RULE_14]
                  bit_cnt <= bit_cnt + 4'd1;
               end else if (ack_phase && i2c_state == I2C_RDATA) begin
                  master_nack <= s_data; // see [RULE_20]
               end
            end else if (i2c_state != I2C_IDLE && clk_fall) begin
               // the line only moves while the clock is low
               if (bit_cnt < `DCP_BYTE_BITS) begin
                  if (i2c_state == I2C_RDATA && bit_cnt != 4'd0) begin
                     i2c_pull <= ~tx_sr[6]; // see [RULE_16]
                     tx_sr <= {tx_sr[6:0], 1'b1};
                  end
               end else if (!ack_phase) begin
                  ack_phase <= 1'b1; // see [RULE_18]
                  case (i2c_state)
                     I2C_DEV: begin
                        if (rx_sr[7:1] == I2C_DEV_ADDR) begin
                           i2c_pull <= 1'b1; // see [RULE_19]
                           master_nack <= 1'b0;
                           second_byte <= 1'b0;
                           i2c_state <= rx_sr[0] ? I2C_RDATA : I2C_REG;
                        end else begin
                           i2c_state <= I2C_IDLE;
                        end
                     end
                     I2C_REG: begin
                        reg_addr <= rx_sr;
                        i2c_pull <= 1'b1; // see [RULE_18]
                        second_byte <= 1'b0;
                        i2c_state <= I2C_WDATA;
                     end
                     I2C_WDATA: begin
                        i2c_pull <= 1'b1; // see [RULE_21]
                        second_byte <= ~second_byte;
                        if (!second_byte) begin
                           hi_hold <= rx_sr; // see [RULE_22]
                        end else begin
                           reg_wdata <= {hi_hold, rx_sr};
                           reg_wr_stb <= 1'b1;
                           addr_inc <= 1'b1; // see [RULE_22]
                        end
                     end
                     default: begin
                        i2c_pull <= 1'b0; // see [RULE_19]
                     end
                  endcase
               end else begin
                  ack_phase <= 1'b0;
                  bit_cnt <= 4'd0;
                  i2c_pull <= 1'b0;
                  if (i2c_state == I2C_RDATA) begin
                     if (master_nack) begin
                        i2c_state <= I2C_IDLE; // see [RULE_20]
                     end else if (!second_byte) begin
                        tx_sr <= reg_rdata[15:8]; // see [RULE_23]
                        i2c_pull <= ~reg_rdata[15];
                        reg_rd_stb <= 1'b1;
                        second_byte <= 1'b1;
                     end else begin
                        tx_sr <= reg_rdata[7:0];
                        i2c_pull <= ~reg_rdata[7];
                        second_byte <= 1'b0;
                        addr_inc <= 1'b1; // see [RULE_23]
                     end
                  end
               end
            end
         end
      end
   end

   // pins and mute all leave from flops; one cycle behind the engines
   always @(posedge clk) begin
      if (srst) begin
         host_data_pin_out <= 1'b0;
         host_data_pin_oe_n <= 1'b1;
         dac_mute <= 1'b0;
         i2c_mode <= 1'b0;
      end else begin
         host_data_pin_out <= s_mode ? 1'b0 : tw_bit; // see [RULE_01]
         host_data_pin_oe_n <= s_mode ? ~i2c_pull : ~tw_drive; // see [RULE_19]
         dac_mute <= s_mode & s_phase; // see [RULE_02]
         i2c_mode <= s_mode;
      end
   end
endmodule // dcp_control_port

//--- verification/dcp_control_port_checker.sv
`timescale 1ns/1ps
module dcp_control_port_checker (
   input wire clk,
   input wire srst,
   input wire protocol_select_strap,
   input wire host_clock_pin,
   input wire host_data_pin_in,
   input wire host_data_pin_out,
   input wire host_data_pin_oe_n,
   input wire host_phase_pin,
   input wire dac_mute,
   input wire i2c_mode,
   input wire [7:0] reg_addr,
   input wire reg_wr_stb,
   input wire [15:0] reg_wdata,
   input wire reg_rd_stb,
   input wire [15:0] reg_rdata,
   input wire reg_exists
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // pin paths pass two sync flops, so allow settling before comparing
   AST_MODE: assert property (
      $stable(protocol_select_strap) [*6] |-> i2c_mode == protocol_select_strap)
      else $error("mode does not follow strap");
   AST_MUTE_I2C: assert property (
      ($stable(host_phase_pin) && i2c_mode) [*6] |-> dac_mute == host_phase_pin)
      else $error("mute does not follow phase pin");
   AST_MUTE_TW: assert property ((!i2c_mode) [*3] |-> !dac_mute)
      else $error("mute set in three-wire mode");
   AST_WR_GAP: assert property (reg_wr_stb |=> !reg_wr_stb [*8])
      else $error("write strobes too close");
   AST_I2C_INC: assert property (
      i2c_mode && reg_wr_stb |=> reg_addr == $past(reg_addr) + 8'h01)
      else $error("pointer not advanced after pair");
   AST_TW_KEEP: assert property (!i2c_mode && reg_wr_stb |=> $stable(reg_addr))
      else $error("three-wire pointer moved");
   AST_TW_QUIET: assert property (
      (!i2c_mode && !host_phase_pin) [*6] |-> host_data_pin_oe_n)
      else $error("driving in address mode");
   AST_I2C_EDGE: assert property (
      i2c_mode && $changed(host_data_pin_oe_n) |-> !host_clock_pin)
      else $error("data changed while clock high");
   AST_TW_FALL: assert property (
      !i2c_mode && !host_data_pin_oe_n && $past(host_data_pin_oe_n) == 1'b0
      && $changed(host_data_pin_out) |-> !host_clock_pin)
      else $error("read bit changed while clock high");
   AST_OPEN_DRAIN: assert property (i2c_mode [*4] |-> !host_data_pin_out)
      else $error("two-wire data driven high");
   cover property (reg_wr_stb && i2c_mode);
   cover property (reg_wr_stb && !i2c_mode);
   cover property ($fell(host_data_pin_oe_n) && !i2c_mode);
endmodule // dcp_control_port_checker

//--- verification/dcp_host_model.sv
`timescale 1ns/1ps
// microcontroller side; open drain is modelled as drv_en pulling low
module dcp_host_model (
   output reg pin_clk,
   output reg pin_phase,
   output reg drv_en,
   output reg drv_val,
   input wire pin_data
);
   integer half;
   initial begin
      pin_clk = 1'b1;
      pin_phase = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b0;
      half = 40;
   end
   task bit_cycle(input en, input val, output s);
      begin
         pin_clk = 1'b0;
         #10 drv_en = en;
         drv_val = val;
         #(half - 10) pin_clk = 1'b1;
         s = pin_data;
         #half;
      end
   endtask
   task tw_phase(input p);
      begin
         half = 40;
         pin_phase = p;
         #40;
      end
   endtask
   task tw_byte(input [7:0] v, input drv, output [7:0] r);
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1)
            bit_cycle(drv, v[i], r[i]);
         drv_en = 1'b0;
      end
   endtask
   // slow two-wire clock costs run time but keeps the host legal
   task i2c_cond(input en_a, input en_b);
      begin
         half = 1250;
         pin_clk = 1'b0;
         #10 drv_en = en_a;
         #(half - 10) pin_clk = 1'b1;
         #half drv_en = en_b;
         #half pin_clk = !en_b;
      end
   endtask
   task i2c_byte(input [7:0] v, input rd, input ack, output [7:0] r, output a);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit_cycle(!rd && !v[i], 1'b0, r[i]);
         bit_cycle(rd && ack, 1'b0, a);
         pin_clk = 1'b0;
      end
   endtask
endmodule // dcp_host_model

//--- verification/dcp_control_port_tb.sv
`timescale 1ns/1ps
module dcp_control_port_tb;
   localparam [5:0] TWA = 6'h2a;
   localparam [6:0] IA = 7'h5a;
   reg clk = 1'b0;
   reg srst, strap, b;
   reg [7:0] salt, lim;
   wire m_clk, m_phase, m_en, m_val, pin_data, d_out, oe_n, dac_mute, i2c_mode, wr_stb, rd_stb;
   wire [7:0] reg_addr;
   wire [15:0] wdata;
   wire [15:0] rdata = {reg_addr ^ salt, ~reg_addr};
   wire exists = reg_addr < lim;
   // released three-wire data toggles, two-wire data has a pull-up
   assign pin_data = strap ? !(!oe_n || m_en) : (!oe_n ? d_out : (m_en ? m_val : clk));
   integer n_mismatch, compares, n_wr, n_rd, cyc, k, seed;
   reg [7:0] wa, r;
   reg [15:0] wd, d;
   reg [31:0] x;
   reg [6:0] a;
   always #2 clk = ~clk;
   dcp_control_port #(.TW_DEV_ADDR(TWA), .I2C_DEV_ADDR(IA)) i_dut (.clk(clk), .srst(srst),
      .protocol_select_strap(strap), .host_clock_pin(m_clk), .host_data_pin_in(pin_data),
      .host_data_pin_out(d_out), .host_data_pin_oe_n(oe_n), .host_phase_pin(m_phase),
      .dac_mute(dac_mute), .i2c_mode(i2c_mode), .reg_addr(reg_addr), .reg_wr_stb(wr_stb),
      .reg_wdata(wdata), .reg_rd_stb(rd_stb), .reg_rdata(rdata), .reg_exists(exists));
   dcp_host_model i_host (.pin_clk(m_clk), .pin_phase(m_phase), .drv_en(m_en),
      .drv_val(m_val), .pin_data(pin_data));
   function [7:0] rev8(input [7:0] v);
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1)
            rev8[i] = v[7 - i];
      end
   endfunction
   function [15:0] mdl(input [7:0] ra);
      mdl = {ra ^ salt, ~ra};
   endfunction
   task chk(input [15:0] got, input [15:0] exp, input [8*24-1:0] msg);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: %0s got %h exp %h", $time, msg, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("mismatches %0d compares %0d", n_mismatch, compares);
         if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (wr_stb === 1'b1) begin
         n_wr = n_wr + 1;
         wa = reg_addr;
         wd = wdata;
      end
      if (rd_stb === 1'b1)
         n_rd = n_rd + 1;
      if (cyc == 97000) begin
         n_mismatch = n_mismatch + 1;
         end_of_test;
      end
   end
   task tw_hdr(input [7:0] ab, input fl, input [6:0] ra);
      begin
         i_host.tw_phase(1'b0);
         i_host.tw_byte(ab, 1'b1, r);
         i_host.tw_phase(1'b1);
         i_host.tw_byte(rev8({fl, ra}), 1'b1, r);
      end
   endtask
   task tw_data(input [15:0] v);
      begin
         i_host.tw_byte(rev8(v[15:8]), 1'b1, r);
         i_host.tw_byte(rev8(v[7:0]), 1'b1, r);
         i_host.tw_phase(1'b0);
         repeat (10) @(posedge clk);
      end
   endtask
   task ib(input [7:0] v, input rd, input ak, input [7:0] e);
      begin
         i_host.i2c_byte(v, rd, ak, r, b);
         chk(rd ? r : b, e, "two-wire byte");
      end
   endtask
   initial begin
      srst = 1'b1;
      strap = 1'b0;
      n_mismatch = 0;
      compares = 0;
      n_wr = 0;
      cyc = 0;
      seed = $urandom(22705);
      n_rd = 0;
      salt = $urandom;
      lim = 8'h40 | ($urandom & 8'h0f);
      repeat (5) @(posedge clk);
      #1 srst = 1'b0;
      repeat (10) @(posedge clk);
      chk({oe_n, i2c_mode, dac_mute, reg_addr}, 11'h400, "reset state");
      for (k = 0; k < 4; k = k + 1) begin
         a = (k == 0) ? 7'h7f : $urandom;
         d = (k == 1) ? 16'h0001 : $urandom;
         n_wr = 0;
         n_rd = 0;
         tw_hdr({TWA, 2'b10}, 1'b0, a);
         tw_data(d);
         chk(n_wr, 1, "tw write count");
         chk(n_rd, 0, "no read strobe");
         chk(wa, {1'b0, a}, "tw write addr");
         chk(wd, d, "tw write data");
      end
      // unused types and a foreign address must be ignored
      for (k = 0; k < 3; k = k + 1) begin
         n_wr = 0;
         tw_hdr((k == 2) ? {TWA ^ 6'h01, 2'b10} : {TWA, 1'b0, k[0]}, 1'b0, 7'h05);
         tw_data(16'h1234);
         chk(n_wr, 0, "refused write");
      end
      for (k = 0; k < 2; k = k + 1) begin
         a = k ? 7'h50 : ($urandom % 64);
         n_rd = 0;
         tw_hdr({TWA, 2'b10}, 1'b1, a);
         i_host.tw_phase(1'b0);
         i_host.tw_byte({TWA, 2'b11}, 1'b1, r);
         i_host.tw_phase(1'b1);
         i_host.tw_byte(8'h00, 1'b0, r);
         chk(r, rev8({{1'b0, a} >= lim, a}), "returned register");
         i_host.tw_byte(8'h00, 1'b0, r);
         chk(r, rev8({1'b0, a} ^ salt), "read high byte");
         i_host.tw_byte(8'h00, 1'b0, r);
         chk(r, rev8(~{1'b0, a}), "read low byte");
         i_host.tw_phase(1'b0);
         repeat (10) @(posedge clk);
         chk(oe_n, 1, "drive released");
         chk(n_rd, 1, "prepare read strobe");
      end
      i_host.tw_phase(1'b1);
      repeat (10) @(posedge clk);
      chk(dac_mute, 0, "no mute three-wire");
      #1 strap = 1'b1;
      repeat (10) @(posedge clk);
      chk({i2c_mode, dac_mute}, 2'b11, "mute two-wire");
      i_host.tw_phase(1'b0);
      repeat (10) @(posedge clk);
      chk(dac_mute, 0, "unmute two-wire");
      a = $urandom % 127;
      x = $urandom;
      n_wr = 0;
      i_host.i2c_cond(1'b0, 1'b1);
      ib({IA, 1'b0}, 1'b0, 1'b0, 8'h00);
      ib({1'b0, a}, 1'b0, 1'b0, 8'h00);
      for (k = 3; k >= 0; k = k - 1)
         ib(x[k * 8 +: 8], 1'b0, 1'b0, 8'h00);
      i_host.i2c_cond(1'b1, 1'b0);
      chk(n_wr, 2, "pair count");
      chk(wa, {1'b0, a} + 8'h01, "pair address");
      chk(wd, x[15:0], "pair data");
      i_host.i2c_cond(1'b0, 1'b1);
      ib({IA ^ 7'h01, 1'b0}, 1'b0, 1'b0, 8'h01);
      i_host.i2c_cond(1'b1, 1'b0);
      x = {mdl({1'b0, a}), mdl({1'b0, a} + 8'h01)};
      n_rd = 0;
      i_host.i2c_cond(1'b0, 1'b1);
      ib({IA, 1'b0}, 1'b0, 1'b0, 8'h00);
      ib({1'b0, a}, 1'b0, 1'b0, 8'h00);
      i_host.i2c_cond(1'b0, 1'b1);
      ib({IA, 1'b1}, 1'b0, 1'b0, 8'h00);
      for (k = 0; k < 4; k = k + 1)
         ib(8'h00, 1'b1, k < 3, x[(3 - k) * 8 +: 8]);
      i_host.i2c_cond(1'b1, 1'b0);
      chk({oe_n, pin_data}, 2'b11, "bus released");
      chk(n_rd, 2, "pair fetch strobes");
      end_of_test;
   end
endmodule // dcp_control_port_tb
bind dcp_control_port dcp_control_port_checker i_chk (.clk, .srst, .protocol_select_strap,
   .host_clock_pin, .host_data_pin_in, .host_data_pin_out, .host_data_pin_oe_n,
   .host_phase_pin, .dac_mute, .i2c_mode, .reg_addr, .reg_wr_stb, .reg_wdata, .reg_rd_stb,
   .reg_rdata, .reg_exists);
